/* rtl/sbd_map.svh */
// Opcodes, flag positions and cycle counts for the shift, branch and bit-clear decoder.
// Assumes inclusion by bare name from the package and the core.
`ifndef SBD_MAP_SVH
`define SBD_MAP_SVH
`define SBD_OP_SRA_ACC 8'h47
`define SBD_OP_SRA_IDX 8'h57
`define SBD_OP_SRA_DIR 8'h37
`define SBD_OP_SRA_IX 8'h77
`define SBD_OP_SRA_IX1 8'h67
`define SBD_OP_BR_FIRST 8'h20
`define SBD_OP_BR_LAST 8'h2F
`define SBD_OP_CLR_BASE 8'h11
`define SBD_OP_CLR_LAST 8'h1F
`define SBD_CC_H 4
`define SBD_CC_I 3
`define SBD_CC_N 2
`define SBD_CC_C 1
`define SBD_CC_Z 0
`define SBD_CC_RESET 5'h08
`define SBD_PC_RESET 16'h0100
`define SBD_BR_STEP 16'h0002
`define SBD_CYC_SRA_REG 4'h3
`define SBD_CYC_SRA_DIR 4'h5
`define SBD_CYC_SRA_IX1 4'h6
`define SBD_CYC_BRANCH 4'h3
`define SBD_CYC_CLR 4'h5
`endif

/* rtl/sbd_pkg.sv */
// Types for the shift, branch and bit-clear decoder.
// Assumes the constants header sits beside it.
`include "sbd_map.svh"
package sbd_pkg;
    typedef enum logic [2:0] {
        SBD_FETCH,
        SBD_OPND,
        SBD_READ,
        SBD_EXEC,
        SBD_WRITE,
        SBD_WAIT
    } sbd_state_t;
    typedef enum logic [2:0] {
        SBD_K_NONE,
        SBD_K_SRA_ACC,
        SBD_K_SRA_IDX,
        SBD_K_SRA_MEM,
        SBD_K_BRANCH,
        SBD_K_CLR
    } sbd_kind_t;
endpackage

/* rtl/sbd_core.sv */
// Decode and execute for arithmetic shift right, relative branches and bit clear.
// Assumes single-cycle synchronous memory: read data valid the cycle after the address.
//
// Overview of operation
// - Shift right loads carry from old bit 0.
// - Negative from result bit 7; zero when all clear.
// - Memory shifts 37, 77 five; 67 six cycles.
// - Taken branch: pc plus two plus offset.
// - 24 carry clear, 25 carry set, three cycles.
// - Opcode 25 branches only with carry set.
// - 27 zero set, 26 zero clear.
// - 28 branches on half carry clear.
// - 29 branches on half carry set.
// - 22 carry and zero clear; 23 either set.
// - 2B negative set, 2A negative clear.
// - 2D mask set, 2C mask clear.
// - 2F pin high, 2E pin low.
// - 20 always, 21 never but skips offset.
// - Bit clear changes only bit n.
// - Bit clear uses direct addresses only.
// - Bit clear opcodes 11 plus twice n, five cycles.
// - Branch offset is signed two's complement.
// - Direct byte gives low address; high is zero.
`timescale 1ns/1ps
`default_nettype none
`include "sbd_map.svh"
module sbd_core (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_int_pin,
    input wire logic [7:0] i_mem_rdata,
    output logic [15:0] o_mem_addr,
    output logic o_mem_rd,
    output logic o_mem_wr,
    output logic [7:0] o_mem_wdata,
    output logic [15:0] o_pc,
    output logic [7:0] o_accumulator,
    output logic [7:0] o_index,
    output logic [4:0] o_condition_code_reg,
    output logic o_illegal,
    output logic o_instr_done
);
    import sbd_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    sbd_state_t state_q;
    sbd_kind_t kind_q;
    logic [15:0] pc_q;
    logic [7:0] acc_q;
    logic [7:0] idx_q;
    logic [4:0] cc_q;
    logic [7:0] op_q;
    logic [7:0] opnd_q;
    logic [7:0] data_q;
    logic [15:0] ea_q;
    logic [3:0] cyc_q;
    logic [3:0] need_q;
    logic illegal_q;
    logic done_q;
    logic wr_q;
    logic pin_meta_q;
    logic pin_q;

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_meta_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            pin_meta_q <= i_int_pin;
            pin_q <= pin_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Decode of the fetched opcode
    // ----------------------------------------------------------------
    sbd_kind_t kind_d;
    logic [3:0] need_d;
    always_comb begin
        kind_d = SBD_K_NONE;
        need_d = 4'h1;
        unique case (i_mem_rdata)
            `SBD_OP_SRA_ACC: begin
                kind_d = SBD_K_SRA_ACC;
                need_d = `SBD_CYC_SRA_REG;
            end
            `SBD_OP_SRA_IDX: begin
                kind_d = SBD_K_SRA_IDX;
                need_d = `SBD_CYC_SRA_REG;
            end
            `SBD_OP_SRA_DIR, `SBD_OP_SRA_IX: begin
                kind_d = SBD_K_SRA_MEM;
                need_d = `SBD_CYC_SRA_DIR;
            end
            `SBD_OP_SRA_IX1: begin
                kind_d = SBD_K_SRA_MEM;
                need_d = `SBD_CYC_SRA_IX1;
            end
            default: begin
                if (i_mem_rdata >= `SBD_OP_BR_FIRST && i_mem_rdata <= `SBD_OP_BR_LAST) begin
                    kind_d = SBD_K_BRANCH;
                    need_d = `SBD_CYC_BRANCH;
                end else if (i_mem_rdata[7:4] == 4'(`SBD_OP_CLR_BASE >> 4) && i_mem_rdata[0]) begin
                    kind_d = SBD_K_CLR;
                    need_d = `SBD_CYC_CLR;
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Branch condition
    // ----------------------------------------------------------------
    logic cond_raw;
    logic take;
    always_comb begin
        unique case (op_q[3:1])
            3'h0: cond_raw = 1'b1;
            3'h1: cond_raw = ~(cc_q[`SBD_CC_C] | cc_q[`SBD_CC_Z]);
            3'h2: cond_raw = ~cc_q[`SBD_CC_C];
            3'h3: cond_raw = ~cc_q[`SBD_CC_Z];
            3'h4: cond_raw = ~cc_q[`SBD_CC_H];
            3'h5: cond_raw = ~cc_q[`SBD_CC_N];
            3'h6: cond_raw = ~cc_q[`SBD_CC_I];
            3'h7: cond_raw = ~pin_q;
        endcase
        // Odd opcodes are the complement of the even condition.
        take = cond_raw ^ op_q[0];
    end

    // ----------------------------------------------------------------
    // Shift result
    // ----------------------------------------------------------------
    logic [7:0] sra_src;
    logic [7:0] sra_res;
    always_comb begin
        unique case (kind_q)
            SBD_K_SRA_ACC: sra_src = acc_q;
            SBD_K_SRA_IDX: sra_src = idx_q;
            default: sra_src = data_q;
        endcase
        sra_res = {sra_src[7], sra_src[7:1]};
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    logic last;
    assign last = (cyc_q + 4'h1 >= need_q);

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= SBD_FETCH;
            kind_q <= SBD_K_NONE;
            op_q <= 8'h00;
            need_q <= 4'h1;
            cyc_q <= 4'h0;
            illegal_q <= 1'b0;
        end else begin
            cyc_q <= cyc_q + 4'h1;
            unique case (state_q)
                SBD_FETCH: begin
                    state_q <= SBD_OPND;
                    cyc_q <= 4'h0;
                end
                SBD_OPND: begin
                    op_q <= i_mem_rdata;
                    kind_q <= kind_d;
                    need_q <= need_d;
                    illegal_q <= (kind_d == SBD_K_NONE);
                    unique case (kind_d)
                        SBD_K_SRA_ACC, SBD_K_SRA_IDX: state_q <= SBD_EXEC;
                        SBD_K_NONE: state_q <= SBD_FETCH;
                        default: state_q <= (i_mem_rdata == `SBD_OP_SRA_IX) ? SBD_READ : SBD_EXEC;
                    endcase
                end
                SBD_EXEC: begin
                    // Branches finish here; memory forms fetched their operand byte.
                    unique case (kind_q)
                        SBD_K_BRANCH, SBD_K_SRA_ACC, SBD_K_SRA_IDX: state_q <= SBD_WAIT;
                        default: state_q <= SBD_READ;
                    endcase
                end
                SBD_READ: state_q <= SBD_WRITE;
                SBD_WRITE: state_q <= SBD_WAIT;
                SBD_WAIT: begin
                    if (last) begin
                        state_q <= SBD_FETCH;
                    end
                end
                default: state_q <= SBD_FETCH;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Write-back slot
    // ----------------------------------------------------------------
    // The write-back falls in the cycle after the read data is captured, whatever the
    // length of the instruction, so direct, indexed and offset forms share one slot.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_q <= 1'b0;
        end else begin
            wr_q <= (state_q == SBD_WRITE);
        end
    end

    // ----------------------------------------------------------------
    // Operand, address and memory data
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            opnd_q <= 8'h00;
            ea_q <= 16'h0000;
            data_q <= 8'h00;
        end else begin
            if (state_q == SBD_OPND && i_mem_rdata == `SBD_OP_SRA_IX) begin
                ea_q <= {8'h00, idx_q};
            end
            if (state_q == SBD_EXEC) begin
                opnd_q <= i_mem_rdata;
                if (op_q == `SBD_OP_SRA_IX1) begin
                    ea_q <= 16'({8'h00, idx_q} + {8'h00, i_mem_rdata});
                end else if (kind_q != SBD_K_BRANCH) begin
                    ea_q <= {8'h00, i_mem_rdata};
                end
            end
            if (state_q == SBD_WRITE) begin
                data_q <= i_mem_rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Program counter
    // ----------------------------------------------------------------
    logic [15:0] rel_ext;
    assign rel_ext = {{8{i_mem_rdata[7]}}, i_mem_rdata};

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            pc_q <= `SBD_PC_RESET;
        end else if (state_q == SBD_OPND && (kind_d == SBD_K_NONE || i_mem_rdata == `SBD_OP_SRA_IX)) begin
            pc_q <= pc_q + 16'h0001;
        end else if (state_q == SBD_EXEC) begin
            if (kind_q == SBD_K_BRANCH && take) begin
                pc_q <= pc_q + `SBD_BR_STEP + rel_ext;
            end else if (kind_q == SBD_K_SRA_ACC || kind_q == SBD_K_SRA_IDX || op_q == `SBD_OP_SRA_IX) begin
                pc_q <= pc_q + 16'h0001;
            end else begin
                pc_q <= pc_q + `SBD_BR_STEP;
            end
        end
    end

    // ----------------------------------------------------------------
    // Accumulator, index and flags
    // ----------------------------------------------------------------
    logic shift_now;
    assign shift_now = (state_q == SBD_EXEC && (kind_q == SBD_K_SRA_ACC || kind_q == SBD_K_SRA_IDX))
        || (state_q == SBD_WAIT && kind_q == SBD_K_SRA_MEM && wr_q);

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            acc_q <= 8'h00;
            idx_q <= 8'h00;
            cc_q <= `SBD_CC_RESET;
        end else if (shift_now) begin
            // Only the shift writes flags; branch and clear paths never reach here.
            if (kind_q == SBD_K_SRA_ACC) begin
                acc_q <= sra_res;
            end
            if (kind_q == SBD_K_SRA_IDX) begin
                idx_q <= sra_res;
            end
            cc_q[`SBD_CC_C] <= sra_src[0];
            cc_q[`SBD_CC_N] <= sra_res[7];
            cc_q[`SBD_CC_Z] <= (sra_res == 8'h00);
        end
    end

    // ----------------------------------------------------------------
    // Memory port
    // ----------------------------------------------------------------
    logic [7:0] clr_mask;
    assign clr_mask = ~(8'h01 << op_q[3:1]);

    always_comb begin
        o_mem_addr = pc_q;
        o_mem_rd = 1'b0;
        o_mem_wr = 1'b0;
        o_mem_wdata = 8'h00;
        unique case (state_q)
            SBD_FETCH: o_mem_rd = 1'b1;
            SBD_OPND: begin
                o_mem_addr = 16'(pc_q + 16'h0001);
                o_mem_rd = (kind_d == SBD_K_BRANCH || kind_d == SBD_K_CLR
                    || (kind_d == SBD_K_SRA_MEM && i_mem_rdata != `SBD_OP_SRA_IX));
            end
            SBD_READ: begin
                o_mem_addr = ea_q;
                o_mem_rd = 1'b1;
            end
            SBD_WAIT: begin
                o_mem_addr = ea_q;
                if (kind_q == SBD_K_CLR && wr_q) begin
                    o_mem_wr = 1'b1;
                    o_mem_wdata = data_q & clr_mask;
                end
                if (kind_q == SBD_K_SRA_MEM && wr_q) begin
                    o_mem_wr = 1'b1;
                    o_mem_wdata = sra_res;
                end
            end
            default: o_mem_addr = pc_q;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == SBD_WAIT && last) || (state_q == SBD_OPND && kind_d == SBD_K_NONE);
        end
    end

    assign o_pc = pc_q;
    assign o_accumulator = acc_q;
    assign o_index = idx_q;
    assign o_condition_code_reg = cc_q;
    assign o_illegal = illegal_q;
    assign o_instr_done = done_q;
endmodule
`default_nettype wire

/* bench/sbd_mem_model.sv */
// Behavioural program and data memory that faces the decoder core.
// Assumes read data is wanted one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module sbd_mem_model (
    input wire logic i_clk_sys,
    input wire logic [15:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:65535];
    // ----
    // Idle cycles invert the previous output, so a stale byte shows again on every second idle cycle.
    // ----
    always @(posedge i_clk_sys) begin
        if (i_rd) begin
            o_rdata <= mem[i_addr];
        end else begin
            o_rdata <= ~o_rdata;
        end
        if (i_wr) begin
            mem[i_addr] <= i_wdata;
        end
    end
endmodule
`default_nettype wire

/* bench/sbd_core_asserts.sv */
// Concurrent checks on the decoder core ports.
// Assumes binding into the core; an opcode outside the block only steps past its byte.
`timescale 1ns/1ps
`default_nettype none
module sbd_core_asserts (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [7:0] i_mem_rdata,
    input wire logic [15:0] o_mem_addr,
    input wire logic o_mem_rd,
    input wire logic o_mem_wr,
    input wire logic [7:0] o_mem_wdata,
    input wire logic [15:0] o_pc,
    input wire logic [4:0] o_condition_code_reg,
    input wire logic o_instr_done
);
    logic want_q, got_q, rgot_q, fetch, clr, smem;
    logic [7:0] op_q, rb_q, rb;
    logic [15:0] fpc_q, ra_q;
    logic [4:0] fcc_q;
    assign fetch = o_mem_rd & (want_q | o_instr_done);
    assign clr = op_q[7:4] == 4'h1 && op_q[0];
    assign smem = op_q == 8'h37 || op_q == 8'h67 || op_q == 8'h77;
    assign rb = rgot_q ? i_mem_rdata : rb_q;
    // ----
    // Tracks the opcode, its address and the flags seen at its fetch.
    // ----
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            want_q <= 1'b1;
            got_q <= 1'b0;
            op_q <= 8'h00;
            fpc_q <= 16'h0000;
            fcc_q <= 5'h00;
        end else begin
            got_q <= fetch;
            if (fetch) begin
                want_q <= 1'b0;
                fpc_q <= o_mem_addr;
                fcc_q <= o_condition_code_reg;
            end else if (o_instr_done) begin
                want_q <= 1'b1;
            end
            if (got_q) begin
                op_q <= i_mem_rdata;
            end
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rgot_q <= 1'b0;
            rb_q <= 8'h00;
            ra_q <= 16'h0000;
        end else begin
            rgot_q <= o_mem_rd;
            if (o_mem_rd) begin
                ra_q <= o_mem_addr;
            end
            if (rgot_q) begin
                rb_q <= i_mem_rdata;
            end
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    chk_addr_page: assert property (o_mem_wr && (clr || op_q == 8'h37) |-> o_mem_addr[15:8] == 8'h00)
        else $error("Data write outside the direct page.");
    chk_rmw_addr: assert property (o_mem_wr |-> o_mem_addr == ra_q)
        else $error("Write address differs from the byte read.");
    chk_clr_data: assert property (o_mem_wr && clr |-> o_mem_wdata == (rb & ~(8'h01 << op_q[3:1])))
        else $error("Bit clear wrote a wrong byte.");
    chk_sra_data: assert property (o_mem_wr && smem |-> o_mem_wdata == {rb[7], rb[7:1]})
        else $error("Memory shift wrote a wrong byte.");
    chk_sra_flags: assert property (o_instr_done && smem |->
        o_condition_code_reg[2:0] == {rb[7], rb[0], rb[7:1] == 7'h00})
        else $error("Memory shift flags wrong.");
    chk_quiet_flags: assert property (o_instr_done && (clr || op_q[7:4] == 4'h2) |->
        o_condition_code_reg == fcc_q)
        else $error("Branch or bit clear changed flags.");
    chk_never_skip: assert property (o_instr_done && op_q == 8'h21 |-> o_pc == fpc_q + 16'h0002)
        else $error("Never-branch did not step over its offset.");
    chk_always_jump: assert property (o_instr_done && op_q == 8'h20 |->
        o_pc == fpc_q + 16'h0002 + {{8{rb[7]}}, rb})
        else $error("Always-branch target wrong.");
    chk_done_bound: assert property (fetch |-> ##[2:12] o_instr_done)
        else $error("Instruction did not finish in time.");
    cover property (o_instr_done && op_q == 8'h20);
    cover property (o_mem_wr && clr);
    cover property (o_instr_done && smem);
endmodule
bind sbd_core sbd_core_asserts i_sbd_core_asserts (.i_clk_sys, .i_nrst, .i_mem_rdata, .o_mem_addr, .o_mem_rd,
    .o_mem_wr, .o_mem_wdata, .o_pc, .o_condition_code_reg, .o_instr_done);
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench: random programs of shifts, branches and bit clears.
// Assumes the core, the memory model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sbd_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_nrst = 1'b0;
    logic i_int_pin = 1'b0;
    logic [15:0] m_addr, pc, xpc;
    logic [7:0] m_rdata, m_wdata, op, opr, v, r, acc, idx;
    logic [7:0] xa = 8'h00;
    logic [7:0] xi = 8'h00;
    logic [4:0] condition_code_reg;
    logic [4:0] xcc = 5'h08;
    logic m_rd, m_wr, done, ill;
    logic [53:0] q [$];
    logic [7:0] mref [0:255];
    logic [31:0] rs = 32'h2BBF;
    int num_errors = 0;
    int comparisons = 0;
    always #2 i_clk_sys = ~i_clk_sys;
    sbd_core i_sbd_core (.i_clk_sys, .i_nrst, .i_int_pin, .i_mem_rdata(m_rdata), .o_mem_addr(m_addr),
        .o_mem_rd(m_rd), .o_mem_wr(m_wr), .o_mem_wdata(m_wdata), .o_pc(pc), .o_accumulator(acc),
        .o_index(idx), .o_condition_code_reg(condition_code_reg), .o_illegal(ill), .o_instr_done(done));
    sbd_mem_model i_sbd_mem_model (.i_clk_sys, .i_addr(m_addr), .i_rd(m_rd), .i_wr(m_wr),
        .i_wdata(m_wdata), .o_rdata(m_rdata));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic close_out();
        $display("Counts: %0d compared, %0d mismatched", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ----
    // Places one random instruction at the model program counter.
    // ----
    task automatic gen(input int k);
        rs = lfsr(rs);
        case (rs[2:0])
            3'h4, 3'h5: op = {4'h1, rs[7:5], 1'b1};
            3'h6: op = rs[8] ? 8'h37 : 8'h47;
            3'h7: op = rs[9] ? 8'h67 : (rs[8] ? 8'h77 : 8'h57);
            default: op = {4'h2, rs[7:4]};
        endcase
        if (k < 16) begin
            op = 8'h20 + 8'(k);
        end
        // One opcode outside the block, which must only step past its own byte.
        if (k == 16) begin
            op = 8'h9D;
        end
        opr = rs[31:24];
        if (opr > 8'hFC || xpc < 16'h0200) begin
            opr[7] = 1'b0;
        end
        i_sbd_mem_model.mem[xpc] = op;
        i_sbd_mem_model.mem[xpc + 16'h0001] = opr;
    endtask
    // ----
    // Reference step: updates the model state and queues the expected result.
    // ----
    task automatic exec();
        logic t;
        logic [7:0] ea;
        ea = 8'h00;
        if (op[7:4] == 4'h2) begin
            case (op[3:1])
                3'h0: t = 1'b1;
                3'h1: t = !(xcc[1] | xcc[0]);
                3'h2: t = !xcc[1];
                3'h3: t = !xcc[0];
                3'h4: t = !xcc[4];
                3'h5: t = !xcc[2];
                3'h6: t = !xcc[3];
                default: t = !i_int_pin;
            endcase
            t = t ^ op[0];
            xpc = xpc + 16'h0002 + (t ? {{8{opr[7]}}, opr} : 16'h0000);
        end else if (op[7:4] == 4'h1) begin
            ea = opr;
            mref[ea][op[3:1]] = 1'b0;
            xpc = xpc + 16'h0002;
        end else if (op == 8'h9D) begin
            xpc = xpc + 16'h0001;
        end else begin
            ea = (op == 8'h37 || op == 8'h67) ? opr : xi;
            v = (op == 8'h47) ? xa : ((op == 8'h57) ? xi : mref[ea]);
            r = {v[7], v[7:1]};
            if (op == 8'h47) begin
                xa = r;
            end else if (op == 8'h57) begin
                xi = r;
            end else begin
                mref[ea] = r;
            end
            xcc[2:0] = {r[7], v[0], r == 8'h00};
            xpc = xpc + ((op == 8'h37 || op == 8'h67) ? 16'h0002 : 16'h0001);
        end
        q.push_back({op == 8'h9D, xa, xi, xpc, xcc, ea, mref[ea]});
    endtask
    always begin
        logic [53:0] e;
        logic [37:0] st;
        @(posedge i_clk_sys);
        #1;
        if (done === 1'b1) begin
            st = {ill, acc, idx, pc, condition_code_reg};
            e = (q.size() > 0) ? q.pop_front() : 54'h0;
            @(posedge i_clk_sys);
            #1;
            comparisons++;
            if ({st, e[15:8], i_sbd_mem_model.mem[e[15:8]]} !== e) begin
                num_errors++;
                $display("BAD t=%0t got=%h exp=%h", $time, {st, e[15:8], i_sbd_mem_model.mem[e[15:8]]}, e);
            end
        end
    end
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        num_errors++;
        $display("BAD t=%0t watchdog expired", $time);
        close_out();
    end
    initial begin
        for (int a = 0; a < 256; a++) begin
            rs = lfsr(rs);
            mref[a] = rs[7:0];
            i_sbd_mem_model.mem[a] = rs[7:0];
        end
        xpc = 16'h0100;
        gen(0);
        repeat (12) @(posedge i_clk_sys);
        #1;
        i_nrst = 1'b1;
        for (int k = 0; k < 400; k++) begin
            exec();
            if (op[7:1] != 7'h17) begin
                i_int_pin = rs[12];
            end
            gen(k + 1);
            do begin
                @(posedge i_clk_sys);
                #1;
            end while (done !== 1'b1);
            if (k == 15) begin
                $display("Test branch opcode sweep finished");
            end
        end
        repeat (3) @(posedge i_clk_sys);
        $display("Test random instruction mix finished");
        close_out();
    end
endmodule
`default_nettype wire
